// >>> logic/blf_core.sv
// Frequency selection, backlight reduce and string fault logic of a three-string backlight driver.
`timescale 1ns/1ps
`include "blf_cfg.svh"
module blf_core
#(
   parameter int OVP_CYCLES = `BLF_OVP_CYCLES,   // Overvoltage duration before flagging.
   parameter int CNT_W      = 17                 // Width of the duration counter.
)
(
   input  wire logic                mclk,
   input  wire logic                rst_b,
   input  wire blf_pkg::blf_reg_req_s reg_req,
   input  wire blf_pkg::blf_sense_s sense_async,
   output logic [7:0]               reg_rdata_q,
   output logic [10:0]              mapper_code_q,
   output blf_pkg::blf_freq_e       freq_sel_q,
   output logic [1:0]               ovp_thr_sel_q,
   output logic                     boost_switch_q,
   output logic                     device_on_q,
   output logic [2:0]               string_en_q
);
   import blf_pkg::*;

   // ----------------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------------
   // The override lands one cycle after the synchronised pin. The assertion window is therefore a few cycles,
   // clipped to the 50 us allowance so that a slower clock cannot make it looser than permitted.
   localparam int REDUCE_MAX = (`BLF_REDUCE_CYCLES < 4) ? `BLF_REDUCE_CYCLES : 4;
   blf_sense_s  s;                                      // Synchronised analogue levels.
   logic [7:0]  en_q, en_d;                             // Function enable register.
   logic [7:0]  brt_ctrl_q, brt_ctrl_d;                 // Brightness control register.
   logic [7:0]  boost_q, boost_d;                       // Boost control register.
   logic [7:0]  af_hi_q, af_hi_d;                       // Auto frequency high threshold.
   logic [7:0]  af_lo_q, af_lo_d;                       // Auto frequency low threshold.
   logic [7:0]  reduce_q, reduce_d;                     // Reduced brightness target.
   logic [7:0]  brt_lo_q, brt_lo_d;                     // Brightness low bits staging.
   logic [7:0]  shdn_q, shdn_d;                         // Fault shutdown enable.
   logic [7:0]  flags_q, flags_d;                       // Latched fault flags.
   logic [10:0] code_q, code_d;                         // Active brightness code.
   logic [10:0] mapper_d;                               // Code presented to the mapper.
   logic [7:0]  rdata_d;                                // Read data.
   blf_freq_e   freq_d;                                 // Next switching frequency.
   blf_boost_e  bst_q, bst_d;                           // Boost guard state.
   logic [CNT_W-1:0] dur_q, dur_d;                      // Overvoltage duration counter.
   logic [1:0]  occ_q, occ_d;                           // Overvoltage occurrences with low sink.
   logic        over_q;                                 // Overvoltage level one cycle ago.
   logic        lock_q, lock_d;                         // Re-enable lockout.
   logic        dev_on_d;                               // Next device enable.
   logic        boost_sw_d;                             // Next boost switching enable.
   logic        wr_en, wr_brt, wr_hi, rd_flags;         // Decoded accesses.
   logic        reduce_act, over, any_low, short_hit;   // Qualified conditions.
   logic        over_rise, dur_hit, occ_hit, shut_evt;  // Fault events.
   logic [7:0]  set_v;                                  // Flag set vector.

   // ----------------------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------------------
   blf_sync #(.W($bits(blf_sense_s))) u_sync
   (
      .mclk  (mclk),
      .rst_b (rst_b),
      .d     (sense_async),
      .q     (s)
   );

   // ----------------------------------------------------------------------------
   // Register decode and next values
   // ----------------------------------------------------------------------------
   // Decode the access, apply writes, and work out the fault events.
   always_comb
   begin
      wr_en    = reg_req.wr && (reg_req.addr == `BLF_OFS_ENABLE);
      wr_brt   = reg_req.wr && (reg_req.addr == `BLF_OFS_BRT_CTRL);
      wr_hi    = reg_req.wr && (reg_req.addr == `BLF_OFS_BRT_HI);
      rd_flags = reg_req.rd && (reg_req.addr == `BLF_OFS_FLAGS);
      // Faults are judged only while the device runs.
      over      = s.ovp_over && device_on_q;
      any_low   = |(s.sink_low & string_en_q);
      short_hit = device_on_q && |(s.short_low & string_en_q);
      over_rise = over && !over_q;
      dur_hit   = over && (dur_q == CNT_W'(OVP_CYCLES));
      occ_hit   = over_rise && any_low && (occ_q == (`BLF_OPEN_EVENTS - 2'd1));
      set_v = 8'h00;
      set_v[`BLF_FLAG_OVP_BIT]   = dur_hit || occ_hit;
      set_v[`BLF_FLAG_OPEN_BIT]  = occ_hit || (dur_hit && any_low);
      set_v[`BLF_FLAG_SHORT_BIT] = short_hit;
      // Reading clears, but a flag raised in the same cycle survives.
      flags_d = (rd_flags ? 8'h00 : flags_q) | set_v;
      // Either overvoltage or open flag may stop the device.
      shut_evt = shdn_q[`BLF_SHDN_OVP_BIT] &&
                 (set_v[`BLF_FLAG_OVP_BIT] || set_v[`BLF_FLAG_OPEN_BIT]);
      lock_d   = shut_evt || (lock_q && !rd_flags);
      // Plain register writes.
      en_d       = wr_en ? {4'h0, reg_req.wdata[3:0]} : en_q;
      brt_ctrl_d = wr_brt ? reg_req.wdata : brt_ctrl_q;
      // Turning the device on restores the default polarity.
      if (wr_en && reg_req.wdata[`BLF_EN_DEV_BIT] && !en_q[`BLF_EN_DEV_BIT])
      begin
         brt_ctrl_d[`BLF_POL_BIT] = 1'b0;
      end
      // While locked out the enable bit cannot be set.
      if (lock_d)
      begin
         en_d[`BLF_EN_DEV_BIT] = 1'b0;
      end
      boost_d  = (reg_req.wr && reg_req.addr == `BLF_OFS_BOOST)   ? reg_req.wdata : boost_q;
      af_hi_d  = (reg_req.wr && reg_req.addr == `BLF_OFS_AF_HIGH) ? reg_req.wdata : af_hi_q;
      af_lo_d  = (reg_req.wr && reg_req.addr == `BLF_OFS_AF_LOW)  ? reg_req.wdata : af_lo_q;
      reduce_d = (reg_req.wr && reg_req.addr == `BLF_OFS_REDUCE)  ? reg_req.wdata : reduce_q;
      brt_lo_d = (reg_req.wr && reg_req.addr == `BLF_OFS_BRT_LO)  ? reg_req.wdata : brt_lo_q;
      shdn_d   = (reg_req.wr && reg_req.addr == `BLF_OFS_SHDN)    ? reg_req.wdata : shdn_q;
      // The low bits only take effect together with the high byte.
      code_d = wr_hi ? {reg_req.wdata, brt_lo_q[2:0]} : code_q;
      dev_on_d = en_d[`BLF_EN_DEV_BIT];
   end

   // Read mux; reserved and unmapped addresses read as zero.
   always_comb
   begin
      rdata_d = reg_rdata_q;
      if (reg_req.rd)
      begin
         unique case (reg_req.addr)
            `BLF_OFS_ENABLE:   rdata_d = en_q;
            `BLF_OFS_BRT_CTRL: rdata_d = brt_ctrl_q;
            `BLF_OFS_BOOST:    rdata_d = boost_q;
            `BLF_OFS_AF_HIGH:  rdata_d = af_hi_q;
            `BLF_OFS_AF_LOW:   rdata_d = af_lo_q;
            `BLF_OFS_REDUCE:   rdata_d = reduce_q;
            `BLF_OFS_BRT_LO:   rdata_d = {5'h00, brt_lo_q[2:0]};
            `BLF_OFS_BRT_HI:   rdata_d = code_q[10:3];
            `BLF_OFS_SHDN:     rdata_d = shdn_q;
            `BLF_OFS_FLAGS:    rdata_d = flags_q;
            default:           rdata_d = 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // Brightness path and frequency choice
   // ----------------------------------------------------------------------------
   // The reduce override is applied in one cycle, far inside the allowed latency.
   always_comb
   begin
      reduce_act = s.reduce_pin ^ brt_ctrl_q[`BLF_POL_BIT];
      mapper_d   = code_q;
      if (reduce_act && ({reduce_q, 3'b000} < code_q))
      begin
         mapper_d = {reduce_q, 3'b000};
      end
      // Thresholds are compared with the stored MSBs, not the reduced code.
      if ((af_hi_q == 8'h00) && (af_lo_q == 8'h00))
      begin
         freq_d = boost_q[`BLF_FREQ_BIT] ? BLF_FREQ_1M : BLF_FREQ_500K;
      end
      else if (code_q[10:3] >= af_hi_q)
      begin
         freq_d = BLF_FREQ_1M;
      end
      else if (code_q[10:3] >= af_lo_q)
      begin
         freq_d = BLF_FREQ_500K;
      end
      else
      begin
         freq_d = BLF_FREQ_250K;
      end
   end

   // ----------------------------------------------------------------------------
   // Overvoltage guard
   // ----------------------------------------------------------------------------
   // Switching stops on overvoltage and resumes once the output is a hysteresis below.
   always_comb
   begin
      bst_d = bst_q;
      unique case (bst_q)
         BLF_BOOST_RUN:  if (over) bst_d = BLF_BOOST_HOLD;
         BLF_BOOST_HOLD: if (s.ovp_below_hyst) bst_d = BLF_BOOST_RUN;
      endcase
      boost_sw_d = dev_on_d && (bst_d == BLF_BOOST_RUN);
      // Saturate so a long fault does not wrap and flag again.
      dur_d = !over ? '0 : ((dur_q > CNT_W'(OVP_CYCLES)) ? dur_q : dur_q + 1'b1);
      // Occurrences are forgotten when the host collects the flags.
      occ_d = occ_q;
      if (rd_flags || occ_hit)
      begin
         occ_d = 2'd0;
      end
      else if (over_rise && any_low)
      begin
         occ_d = occ_q + 2'd1;
      end
   end

   // ----------------------------------------------------------------------------
   // State registers
   // ----------------------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         en_q <= `BLF_RST_BYTE;  brt_ctrl_q <= `BLF_RST_BYTE;  boost_q <= `BLF_RST_BYTE;
         af_hi_q <= `BLF_RST_BYTE;  af_lo_q <= `BLF_RST_BYTE;  reduce_q <= `BLF_RST_BYTE;
         brt_lo_q <= `BLF_RST_BYTE;  shdn_q <= `BLF_RST_BYTE;  flags_q <= `BLF_RST_BYTE;
         code_q <= `BLF_RST_CODE;  mapper_code_q <= `BLF_RST_CODE;  reg_rdata_q <= `BLF_RST_BYTE;
         freq_sel_q <= BLF_FREQ_500K;  bst_q <= BLF_BOOST_RUN;  dur_q <= '0;  occ_q <= 2'd0;
         over_q <= 1'b0;  lock_q <= 1'b0;  device_on_q <= 1'b0;  boost_switch_q <= 1'b0;
         string_en_q <= 3'b000;  ovp_thr_sel_q <= 2'b00;
      end
      else
      begin
         en_q <= en_d;  brt_ctrl_q <= brt_ctrl_d;  boost_q <= boost_d;
         af_hi_q <= af_hi_d;  af_lo_q <= af_lo_d;  reduce_q <= reduce_d;
         brt_lo_q <= brt_lo_d;  shdn_q <= shdn_d;  flags_q <= flags_d;
         code_q <= code_d;  mapper_code_q <= mapper_d;  reg_rdata_q <= rdata_d;
         freq_sel_q <= freq_d;  bst_q <= bst_d;  dur_q <= dur_d;  occ_q <= occ_d;
         over_q <= over;  lock_q <= lock_d;  device_on_q <= dev_on_d;  boost_switch_q <= boost_sw_d;
         string_en_q <= en_d[3:1];
         ovp_thr_sel_q <= boost_d[`BLF_OVP_SEL_LO +: 2];
      end
   end

   // ----------------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   sequence s_reduce_held;
      (reduce_act && ({reduce_q, 3'b000} < code_q) && !wr_hi) [*2];
   endsequence

   property p_auto_off;
      (af_hi_q == 8'h00 && af_lo_q == 8'h00 && boost_q[`BLF_FREQ_BIT]) |=> (freq_sel_q == BLF_FREQ_1M);
   endproperty
   a_auto_off: assert property (p_auto_off) else $error("fixed frequency not followed");

   property p_auto_low;
      (af_lo_q != 8'h00 && code_q[10:3] < af_lo_q) |=> (freq_sel_q == BLF_FREQ_250K);
   endproperty
   a_auto_low: assert property (p_auto_low) else $error("low band not selected");

   property p_code_hold;
      !wr_hi |=> (code_q == $past(code_q));
   endproperty
   a_code_hold: assert property (p_code_hold) else $error("code moved without high write");

   property p_never_raise;
      1'b1 |=> (mapper_code_q <= $past(code_q));
   endproperty
   a_never_raise: assert property (p_never_raise) else $error("reduce raised the current");

   property p_reduce_apply;
      s_reduce_held |-> ##[1:REDUCE_MAX] (mapper_code_q == {reduce_q, 3'b000});
   endproperty
   a_reduce_apply: assert property (p_reduce_apply) else $error("reduced code not applied");

   property p_release;
      !reduce_act |=> (mapper_code_q == $past(code_q));
   endproperty
   a_release: assert property (p_release) else $error("brightness not restored");

   property p_ovp_stop;
      (over && !s.ovp_below_hyst) |=> !boost_switch_q ##1 !boost_switch_q;
   endproperty
   a_ovp_stop: assert property (p_ovp_stop) else $error("boost kept switching in overvoltage");

   property p_dur_flag;
      dur_hit |=> flags_q[`BLF_FLAG_OVP_BIT];
   endproperty
   a_dur_flag: assert property (p_dur_flag) else $error("long overvoltage not flagged");

   property p_open3;
      occ_hit |=> (flags_q[`BLF_FLAG_OVP_BIT] && flags_q[`BLF_FLAG_OPEN_BIT]);
   endproperty
   a_open3: assert property (p_open3) else $error("third occurrence not flagged");

   property p_lockout;
      lock_q && !rd_flags |=> !device_on_q;
   endproperty
   a_lockout: assert property (p_lockout) else $error("device enabled during lockout");

   property p_short;
      short_hit |=> flags_q[`BLF_FLAG_SHORT_BIT];
   endproperty
   a_short: assert property (p_short) else $error("short not flagged");

   property p_sticky;
      (flags_q[`BLF_FLAG_OPEN_BIT] && !rd_flags) |=> flags_q[`BLF_FLAG_OPEN_BIT];
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag dropped without read");

   property p_read_release;
      (rd_flags && lock_q && !shut_evt) |=> !lock_q;
   endproperty
   a_read_release: assert property (p_read_release) else $error("read did not release lockout");

endmodule // blf_core

// >>> logic/blf_cfg.svh
// Register offsets, field positions, reset values and timing counts of the backlight control logic.
`ifndef BLF_CFG_SVH
`define BLF_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define BLF_OFS_ENABLE     8'h10
`define BLF_OFS_BRT_CTRL   8'h11
`define BLF_OFS_BOOST      8'h13
`define BLF_OFS_AF_HIGH    8'h15
`define BLF_OFS_AF_LOW     8'h16
`define BLF_OFS_REDUCE     8'h17
`define BLF_OFS_BRT_LO     8'h18
`define BLF_OFS_BRT_HI     8'h19
`define BLF_OFS_SHDN       8'h1e
`define BLF_OFS_FLAGS      8'h1f

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BLF_EN_DEV_BIT     0
`define BLF_POL_BIT        0
`define BLF_FREQ_BIT       5
`define BLF_OVP_SEL_LO     2
`define BLF_FLAG_OVP_BIT   0
`define BLF_FLAG_SHORT_BIT 3
`define BLF_FLAG_OPEN_BIT  4
`define BLF_SHDN_OVP_BIT   0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define BLF_RST_BYTE       8'h00
`define BLF_RST_CODE       11'h000

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define BLF_CLK_MHZ        40
`define BLF_OVP_TIME_US    1000
`define BLF_OVP_CYCLES     (`BLF_OVP_TIME_US * `BLF_CLK_MHZ)
`define BLF_REDUCE_TIME_US 50
`define BLF_REDUCE_CYCLES  (`BLF_REDUCE_TIME_US * `BLF_CLK_MHZ)
`define BLF_OPEN_EVENTS    2'd3

`endif

// >>> logic/blf_pkg.sv
// Types shared by the backlight control logic.
package blf_pkg;

   // Boost switching frequency chosen for the analogue stage.
   typedef enum logic [1:0] {
      BLF_FREQ_250K = 2'b00,
      BLF_FREQ_500K = 2'b01,
      BLF_FREQ_1M   = 2'b10
   } blf_freq_e;

   // Boost switching state of the overvoltage guard.
   typedef enum logic {
      BLF_BOOST_RUN  = 1'b0,
      BLF_BOOST_HOLD = 1'b1
   } blf_boost_e;

   // One register access from the serial front end.
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } blf_reg_req_s;

   // Comparator and pin levels from the analogue side.
   typedef struct packed {
      logic       reduce_pin;
      logic       ovp_over;
      logic       ovp_below_hyst;
      logic [2:0] sink_low;
      logic [2:0] short_low;
   } blf_sense_s;

endpackage

// >>> logic/blf_sync.sv
// Two-stage synchroniser bank for asynchronous levels.
`timescale 1ns/1ps
module blf_sync
#(
   parameter int W = 1
)
(
   input  wire logic         mclk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   // ----------------------------------------------------------------------------
   // One pair of flops per bit
   // ----------------------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         logic meta_q;   // First stage, read only by the second stage.
         logic sync_q;   // Second stage, safe to use.
         // The first flop may go metastable; only the second one is exported.
         always_ff @(posedge mclk or negedge rst_b)
         begin
            if (!rst_b)
            begin
               meta_q <= 1'b0;
               sync_q <= 1'b0;
            end
            else
            begin
               meta_q <= d[i];
               sync_q <= meta_q;
            end
         end
         assign q[i] = sync_q;
      end
   endgenerate
endmodule // blf_sync

// >>> dv/blf_host.sv
// Host model that drives register reads and writes into the backlight control logic.
`timescale 1ns/1ps
module blf_host
(
   input  wire logic             mclk,
   output blf_pkg::blf_reg_req_s reg_req,
   input  wire logic [7:0]       reg_rdata_q
);
   import blf_pkg::*;
   // The bus is idle until the first task call.
   initial reg_req = '0;
   // One write strobe; address and data stand across the single taking edge.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk) #1;
      reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge mclk) #1;
      reg_req = '0;
   endtask
   // One read strobe; data is registered at the taking edge and read once settled.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk) #1;
      reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge mclk) #1;
      reg_req = '0;
      d = reg_rdata_q;
   endtask
endmodule // blf_host

// >>> dv/test_blf_core.sv
// Self-checking bench for the backlight control logic.
`timescale 1ns/1ps
module test_blf_core;
   import blf_pkg::*;
   localparam int OVERVOLTAGE_PROTECT = 20;      // Short overvoltage duration keeps the run brief.
   logic          mclk;          // 40 MHz clock.
   logic          rst_b;         // Active-low reset.
   blf_reg_req_s  reg_req;       // Requests from the host model.
   blf_sense_s    sense;         // Analogue levels driven by the bench.
   logic [7:0]    reg_rdata_q;   // Read data.
   logic [10:0]   mapper_code_q; // Code to the mapper.
   blf_freq_e     freq_sel_q;    // Selected frequency.
   logic [1:0]    ovp_thr_sel_q; // Overvoltage threshold select.
   logic          boost_switch_q;
   logic          device_on_q;
   logic [2:0]    string_en_q;
   int            failures = 0;
   int            n_checks = 0;
   int            cycles   = 0;
   blf_host host (.mclk(mclk), .reg_req(reg_req), .reg_rdata_q(reg_rdata_q));
   blf_core #(.OVP_CYCLES(OVERVOLTAGE_PROTECT)) uut (.mclk(mclk), .rst_b(rst_b), .reg_req(reg_req), .sense_async(sense),
      .reg_rdata_q(reg_rdata_q), .mapper_code_q(mapper_code_q), .freq_sel_q(freq_sel_q),
      .ovp_thr_sel_q(ovp_thr_sel_q), .boost_switch_q(boost_switch_q), .device_on_q(device_on_q),
      .string_en_q(string_en_q));
   // -------------------------------------------------------------------------
   // Shared helpers
   // -------------------------------------------------------------------------
   // Compare with case equality so an unknown never counts as a match.
   task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Read one register and compare it.
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      host.rd(a, d);
      check($sformatf("reg %h", a), {3'h0, d}, {3'h0, exp});
   endtask
   // Sense levels pass two sync flops, so a few cycles are always allowed.
   task automatic wt(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic results();
      $display("Checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // -------------------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------------------
   task automatic t_reset();
      logic [7:0] ofs [9] = '{8'h10, 8'h11, 8'h13, 8'h17, 8'h18, 8'h19, 8'h1e, 8'h1f, 8'h20};
      check("freq", freq_sel_q, 11'h001);
      foreach (ofs[i]) rdc(ofs[i], 8'h00);
   endtask
   task automatic t_code();
      host.wr(8'h18, 8'h05);
      wt(3);
      check("code", mapper_code_q, 11'h000);
      host.wr(8'h19, 8'ha0);
      wt(3);
      check("code", mapper_code_q, {8'ha0, 3'h5});
   endtask
   task automatic t_freq();
      logic [7:0] cd [4] = '{8'h80, 8'h7f, 8'h40, 8'h3f};
      logic [1:0] fe [4] = '{2'd2, 2'd1, 2'd1, 2'd0};
      host.wr(8'h13, 8'h20);
      wt(3);
      check("freq", freq_sel_q, 11'h002);
      host.wr(8'h13, 8'h00);
      host.wr(8'h15, 8'h80);
      wt(3);
      check("freq", freq_sel_q, 11'h002);
      host.wr(8'h16, 8'h40);
      foreach (cd[i])
      begin
         host.wr(8'h19, cd[i]);
         wt(3);
         check("freq", freq_sel_q, {9'h0, fe[i]});
      end
      // The low threshold goes first, so that no high threshold below it is ever programmed.
      host.wr(8'h16, 8'h00);
      host.wr(8'h15, 8'h00);
      wt(3);
      check("freq", freq_sel_q, 11'h001);
      host.wr(8'h19, 8'ha0);
   endtask
   task automatic t_reduce();
      host.wr(8'h17, 8'h30);
      sense.reduce_pin = 1'b1;
      wt(6);
      check("reduce", mapper_code_q, {8'h30, 3'h0});
      sense.reduce_pin = 1'b0;
      wt(6);
      check("reduce", mapper_code_q, {8'ha0, 3'h5});
      host.wr(8'h17, 8'hc0);
      sense.reduce_pin = 1'b1;
      wt(6);
      check("reduce", mapper_code_q, {8'ha0, 3'h5});
      sense.reduce_pin = 1'b0;
      host.wr(8'h17, 8'h30);
      host.wr(8'h11, 8'h01);
      wt(6);
      check("reduce", mapper_code_q, {8'h30, 3'h0});
      sense.reduce_pin = 1'b1;
      wt(6);
      check("reduce", mapper_code_q, {8'ha0, 3'h5});
      host.wr(8'h11, 8'h00);
   endtask
   task automatic t_ovp();
      host.wr(8'h13, 8'h0c);
      host.wr(8'h10, 8'h03);
      check("thr", ovp_thr_sel_q, 11'h003);
      check("strings", string_en_q, 11'h001);
      sense.ovp_over = 1'b1;
      sense.ovp_below_hyst = 1'b0;
      wt(4);
      check("boost", boost_switch_q, 11'h000);
      wt(OVERVOLTAGE_PROTECT + 10);
      sense.ovp_over = 1'b0;
      wt(4);
      check("boost", boost_switch_q, 11'h000);
      sense.ovp_below_hyst = 1'b1;
      wt(4);
      check("boost", boost_switch_q, 11'h001);
      rdc(8'h1f, 8'h01);
      rdc(8'h1f, 8'h00);
   endtask
   task automatic t_open();
      host.wr(8'h1e, 8'h01);
      // Open test set-up: all strings on, full brightness, brightness mode zero.
      host.wr(8'h10, 8'h0f);
      host.wr(8'h18, 8'h07);
      host.wr(8'h19, 8'hff);
      host.wr(8'h11, 8'h00);
      check("strings", string_en_q, 11'h007);
      sense.sink_low = 3'b001;
      repeat (3)
      begin
         sense.ovp_over = 1'b1;
         sense.ovp_below_hyst = 1'b0;
         wt(4);
         // The output falls through the threshold before it reaches the hysteresis level.
         sense.ovp_over = 1'b0;
         wt(2);
         sense.ovp_below_hyst = 1'b1;
         wt(4);
      end
      sense.sink_low = 3'b000;
      check("on", device_on_q, 11'h000);
      host.wr(8'h10, 8'h03);
      wt(2);
      check("on", device_on_q, 11'h000);
      rdc(8'h1f, 8'h11);
      host.wr(8'h10, 8'h03);
      wt(2);
      check("on", device_on_q, 11'h001);
   endtask
   // Only string one is enabled while shorts are looked for.
   task automatic t_short();
      // Short test set-up: string one only, fault shutdown enable left on; brightness stays full from the open test.
      host.wr(8'h10, 8'h03);
      host.wr(8'h1e, 8'h01);
      host.wr(8'h11, 8'h00);
      // The flag sets within a few cycles, so a short wait stands in for the host's 4 ms.
      sense.short_low = 3'b001;
      wt(5);
      sense.short_low = 3'b000;
      wt(5);
      rdc(8'h1f, 8'h08);
      check("on", device_on_q, 11'h001);
      host.wr(8'h10, 8'h00);
      check("on", device_on_q, 11'h000);
      check("strings", string_en_q, 11'h000);
   endtask
   // -------------------------------------------------------------------------
   // Clock, watchdog and main sequence
   // -------------------------------------------------------------------------
   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // A hang is counted as a mismatch and ends the run.
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         results();
      end
   end
   initial
   begin
      rst_b = 1'b0;
      sense = '{reduce_pin: 1'b0, ovp_over: 1'b0, ovp_below_hyst: 1'b1, sink_low: 3'h0, short_low: 3'h0};
      repeat (12) @(posedge mclk);
      #1;
      rst_b = 1'b1;
      t_reset();
      t_code();
      t_freq();
      t_reduce();
      t_ovp();
      t_open();
      t_short();
      results();
   end
endmodule // test_blf_core
